// ---- core/sync_serial_frame_responder.sv ----
// Summary of operation
// - Phase 0: slave drives first bit at select.
// - Pol0 phase0: sample rising, change falling.
// - Phase 1: first bits with first clock edge.
// - Pol0 phase1: sample falling, change rising.
// - Pol1 phase0: sample falling, change rising.
// - Pol1 phase1: sample rising, change falling.
// - Slave waits one clock, replies 4-16 bits.
// - Select low whole frame; reply line floats.
// - Control sampled rising; reply driven falling.
// - Slave floats line after LSB or select.
// - Frames 4 to 16 bits, MSB first.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps

module sync_serial_frame_responder (
    input  wire logic                              clk_sys_i,         // System clock.
    input  wire logic                              reset_n_i,         // Sync reset, low.
    input  wire logic [sync_serial_pkg::ADDR_W-1:0] reg_addr_i,       // Register address.
    input  wire logic [sync_serial_pkg::DATA_W-1:0] reg_wdata_i,      // Write data.
    input  wire logic                              reg_wr_i,          // Write strobe.
    input  wire logic                              reg_rd_i,          // Read strobe.
    output logic      [sync_serial_pkg::DATA_W-1:0] reg_rdata_o,      // Read data, next cycle.
    input  wire logic                              serial_clock_i,    // Link clock pin.
    input  wire logic                              frame_select_i,    // Frame select pin.
    input  wire logic                              tx_data_line_i,    // Data from the master.
    output logic                                   rx_data_line_o,    // Data to the master.
    output logic                                   rx_data_line_oe_o  // Drive enable.
);

    // ************************************************************************
    // Functions
    // ************************************************************************

    // Bit of a word at the position of the top bit for a given size code.
    function automatic logic msb_of(input logic [15:0] word, input logic [3:0] top);
        msb_of = word[top];
    endfunction

    // Mask that keeps the low bits up to and including the top position.
    function automatic logic [15:0] size_mask(input logic [3:0] top);
        size_mask = 16'hffff >> (4'hf - top);
    endfunction

    // ************************************************************************
    // Pin synchroniser
    // ************************************************************************

    sync_serial_pkg::pins_t s1_q;
    sync_serial_pkg::pins_t s2_q;
    sync_serial_pkg::pins_t s3_q;

    // Pins come from another domain; the link clock runs far slower than clk_sys_i
    // so two stages plus an edge stage see every serial clock level.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            s1_q <= sync_serial_pkg::PINS_IDLE;
            s2_q <= sync_serial_pkg::PINS_IDLE;
            s3_q <= sync_serial_pkg::PINS_IDLE;
        end else begin
            s1_q <= {serial_clock_i, frame_select_i, tx_data_line_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ************************************************************************
    // Control registers and edge decoding
    // ************************************************************************

    sync_serial_pkg::ctrl_t ctrl_q;
    logic [15:0]            reply_q;
    logic [15:0]            rx_sh_q;
    logic [15:0]            rx_word_q;
    logic [15:0]            tx_sh_q;
    logic [4:0]             bitcnt_q;
    logic                   first_q;
    logic                   rx_valid_q;
    logic                   overrun_q;
    logic                   sdo_q;
    logic                   oe_q;
    logic [31:0]            rdata_q;

    wire sclk_rise = s2_q.sclk & ~s3_q.sclk;
    wire sclk_fall = ~s2_q.sclk & s3_q.sclk;
    wire in_frame  = ~s2_q.fss & ctrl_q.enable;
    wire fss_fall  = s3_q.fss & in_frame;
    wire spi_mode  = (ctrl_q.fmt == sync_serial_pkg::FMT_SPI);
    wire mw_mode   = (ctrl_q.fmt == sync_serial_pkg::FMT_CMDRESP);

    // Leading edge leaves the parked level; phase picks which edge samples.
    wire lead_edge  = ctrl_q.cpol ? sclk_fall : sclk_rise;
    wire trail_edge = ctrl_q.cpol ? sclk_rise : sclk_fall;
    wire spi_sample = in_frame & spi_mode & ~fss_fall & (ctrl_q.cpha ? trail_edge : lead_edge);
    wire spi_shift  = in_frame & spi_mode & ~fss_fall & (ctrl_q.cpha ? lead_edge : trail_edge);
    wire mw_rise    = in_frame & mw_mode & ~fss_fall & sclk_rise;
    wire mw_fall    = in_frame & mw_mode & ~fss_fall & sclk_fall;

    // Word boundaries; SPI and reply bit counts follow the programmed size, the control word is CMD_BITS long; MSB first.
    wire [4:0] top_bit        = {1'b0, ctrl_q.data_size_select};
    wire [4:0] reply_first    = sync_serial_pkg::CMD_BITS + sync_serial_pkg::WAIT_BITS;
    wire       spi_last       = spi_sample & (bitcnt_q == top_bit);
    wire       mw_ctl_bit     = mw_rise & (bitcnt_q < sync_serial_pkg::CMD_BITS);
    wire       mw_ctl_last    = mw_rise & (bitcnt_q == sync_serial_pkg::CMD_BITS - 5'h01);
    wire       mw_reply_last  = mw_rise & (bitcnt_q == reply_first + top_bit);
    wire       mw_reply_start = mw_fall & (bitcnt_q == reply_first);
    wire       mw_reply_shift = mw_fall & (bitcnt_q > reply_first);
    wire       push           = spi_last | mw_ctl_last;
    wire       reply_msb      = msb_of(reply_q, ctrl_q.data_size_select);
    wire [15:0] tx_next       = {tx_sh_q[14:0], 1'b0};
    wire [15:0] rx_sh_d       = {rx_sh_q[14:0], s2_q.mosi};
    wire [3:0]  cap_top       = mw_mode ? 4'h7 : ctrl_q.data_size_select;

    // Register port decode.
    wire wr_ctrl   = reg_wr_i & (reg_addr_i == sync_serial_pkg::OFS_CTRL);
    wire wr_reply  = reg_wr_i & (reg_addr_i == sync_serial_pkg::OFS_REPLY);
    wire rd_rxword = reg_rd_i & (reg_addr_i == sync_serial_pkg::OFS_RXWORD);
    wire rd_status = reg_rd_i & (reg_addr_i == sync_serial_pkg::OFS_STATUS);

    // Configuration writes. Changing format mid-frame is allowed but garbles that frame.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ctrl_q  <= sync_serial_pkg::CTRL_RESET;
            reply_q <= sync_serial_pkg::REPLY_RESET;
        end else begin
            if (wr_ctrl) ctrl_q <= sync_serial_pkg::ctrl_t'(reg_wdata_i[sync_serial_pkg::CTRL_W-1:0]);
            if (wr_reply) reply_q <= reg_wdata_i[15:0];
        end
    end

    // ************************************************************************
    // Bit counting
    // ************************************************************************

    // Counts sample edges; in command format the counter spans control, wait and reply.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !in_frame || fss_fall) begin
            bitcnt_q <= 5'h00;
        end else if (spi_sample) begin
            bitcnt_q <= spi_last ? 5'h00 : bitcnt_q + 5'h01;
        end else if (mw_rise) begin
            bitcnt_q <= mw_reply_last ? 5'h00 : bitcnt_q + 5'h01;
        end
    end

    // Marks a word start so the next shift edge reloads the reply instead of shifting.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            first_q <= 1'b1;
        end else if (fss_fall || spi_last) begin
            // Phase 0 has its word loaded at the select fall, so its first shift edge
            // must shift; between words it waits for a select pulse to reload.
            first_q <= ctrl_q.cpha;
        end else if (spi_shift) begin
            first_q <= 1'b0;
        end
    end

    // ************************************************************************
    // Reply line driver
    // ************************************************************************

    // The line floats outside frames, so a released select always frees the wire.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !in_frame) begin
            tx_sh_q <= 16'h0000;
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else if (fss_fall) begin
            tx_sh_q <= reply_q;
            sdo_q   <= spi_mode & ~ctrl_q.cpha & reply_msb;
            oe_q    <= spi_mode & ~ctrl_q.cpha;
        end else if (spi_shift && first_q) begin
            tx_sh_q <= reply_q;
            sdo_q   <= reply_msb;
            oe_q    <= 1'b1;
        end else if (spi_shift) begin
            tx_sh_q <= tx_next;
            sdo_q   <= msb_of(tx_next, ctrl_q.data_size_select);
        end else if (mw_reply_start) begin
            tx_sh_q <= reply_q;
            sdo_q   <= reply_msb;
            oe_q    <= 1'b1;
        end else if (mw_reply_shift) begin
            tx_sh_q <= tx_next;
            sdo_q   <= msb_of(tx_next, ctrl_q.data_size_select);
        end else if (mw_fall) begin
            oe_q    <= 1'b0;
        end
    end

    assign rx_data_line_o    = sdo_q;
    assign rx_data_line_oe_o = oe_q;

    // ************************************************************************
    // Receive capture
    // ************************************************************************

    // Sampled bits enter at the bottom; the shifter restarts at every word boundary.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || fss_fall || push) begin
            rx_sh_q <= 16'h0000;
        end else if (spi_sample || mw_ctl_bit) begin
            rx_sh_q <= rx_sh_d;
        end
    end

    // A new word beats a read in the same cycle, so no word is silently lost.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rx_word_q  <= 16'h0000;
            rx_valid_q <= 1'b0;
            overrun_q  <= 1'b0;
        end else begin
            if (push) rx_word_q <= rx_sh_d & size_mask(cap_top);
            rx_valid_q <= push | (rx_valid_q & ~rd_rxword);
            overrun_q  <= (push & rx_valid_q & ~rd_rxword) | (overrun_q & ~rd_status);
        end
    end

    // ************************************************************************
    // Register read port
    // ************************************************************************

    wire [31:0] status_word = {29'h0, overrun_q, in_frame, rx_valid_q};
    wire [31:0] rd_mux = (reg_addr_i == sync_serial_pkg::OFS_CTRL)   ? {23'h0, ctrl_q}     :
                         (reg_addr_i == sync_serial_pkg::OFS_REPLY)  ? {16'h0, reply_q}    :
                         (reg_addr_i == sync_serial_pkg::OFS_RXWORD) ? {16'h0, rx_word_q}  :
                         (reg_addr_i == sync_serial_pkg::OFS_STATUS) ? status_word         :
                                                                       32'h0;

    // Read data stand for exactly one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) rdata_q <= 32'h0;
        else rdata_q <= reg_rd_i ? rd_mux : 32'h0;
    end

    assign reg_rdata_o = rdata_q;

    // ************************************************************************
    // Assertions
    // ************************************************************************

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_phase0_open;
        fss_fall && spi_mode && !ctrl_q.cpha;
    endsequence

    sequence s_phase1_open;
        fss_fall && spi_mode && ctrl_q.cpha;
    endsequence

    a_phase0_first_bit: assert property (s_phase0_open |=> oe_q && sdo_q == $past(reply_msb))
        else $error("phase 0 first bit not driven at select fall");
    a_phase1_quiet: assert property (s_phase1_open |=> !oe_q)
        else $error("phase 1 drove data before the first clock edge");
    a_phase1_drive: assert property (spi_shift && first_q |=> oe_q && sdo_q == $past(reply_msb))
        else $error("first shift edge did not present the reply MSB");
    a_spi_data_hold: assert property (in_frame && spi_mode && !spi_shift && !fss_fall |=> $stable(sdo_q))
        else $error("reply bit changed off the shift edge");
    a_ctrl_line_float: assert property (mw_ctl_bit |-> !oe_q)
        else $error("reply line driven during the control word");
    a_reply_start: assert property (mw_reply_start |=> oe_q && sdo_q == $past(reply_msb))
        else $error("reply did not start after the wait clock");
    a_select_release: assert property (!in_frame ##1 !in_frame |-> !oe_q)
        else $error("reply line still driven with select high");
    a_word_push: assert property (spi_last |=> rx_valid_q ##1 rx_valid_q || $past(rd_rxword))
        else $error("completed word not flagged");
    a_cmd_capture: assert property (mw_ctl_last |=> rx_valid_q && rx_word_q[15:8] == 8'h00)
        else $error("control word not captured as 8 bits");
    a_read_clear: assert property (rd_rxword && !push |=> !rx_valid_q)
        else $error("reading the received word did not clear its flag");

    // Command format wait clock: the control word has ended, the reply not begun.
    sequence s_cmd_wait;
        mw_rise && bitcnt_q == sync_serial_pkg::CMD_BITS;
    endsequence

    a_wait_quiet: assert property (s_cmd_wait |-> !oe_q)
        else $error("reply line driven during the wait clock");
    a_reply_release: assert property (mw_fall && bitcnt_q == 5'h00 |=> !oe_q)
        else $error("reply line still driven after the last reply bit");
    a_phase0_no_reload: assert property (s_phase0_open |=> !first_q)
        else $error("phase 0 would reload the reply on its first shift edge");
    a_overrun_set: assert property (push && rx_valid_q && !rd_rxword |=> overrun_q)
        else $error("unread word overwritten without the overrun flag");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data shown without a read strobe");

endmodule

// ---- core/sync_serial_pkg.sv ----
// ****************************************************************************
// Shared constants and carriers for the serial frame responder.
// ****************************************************************************
package sync_serial_pkg;

    // Register port geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;

    // Register offsets (byte addresses, one word each).
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_REPLY  = 8'h04;
    localparam logic [7:0] OFS_RXWORD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;

    // Control register layout; the ctrl_t struct below follows it bit for bit.
    localparam int CTRL_W = 9;

    // Status register bit positions.
    localparam int STAT_RXV_BIT  = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_OVR_BIT  = 2;

    // Frame format codes of the frame_format_select field.
    localparam logic [1:0] FMT_SPI     = 2'h0;
    localparam logic [1:0] FMT_PULSE   = 2'h1;
    localparam logic [1:0] FMT_CMDRESP = 2'h2;

    // Command-response framing: control word length and turnaround clocks.
    localparam logic [4:0] CMD_BITS  = 5'h08;
    localparam logic [4:0] WAIT_BITS = 5'h01;

    // Control fields: enable, data_size_select, clock_phase, clock_polarity, format.
    typedef struct packed {
        logic       enable;
        logic [3:0] data_size_select;
        logic       cpha;
        logic       cpol;
        logic [1:0] fmt;
    } ctrl_t;

    // Serial pins as seen from this end, carried through the synchroniser.
    typedef struct packed {
        logic sclk;
        logic fss;
        logic mosi;
    } pins_t;

    // Reset values.
    localparam ctrl_t CTRL_RESET        = 9'h070;
    localparam logic [15:0] REPLY_RESET = 16'h0000;
    localparam pins_t PINS_IDLE         = 3'h2;

endpackage

// ---- tb/serial_master_model.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Master end of the link: owns the clock, select and outgoing data.
// ****************************************************************
module serial_master_model #(
    parameter int HALF = 4 // System clocks per half link period.
) (
    input  wire logic   clk_sys_i,        // System clock.
    input  wire logic   rx_data_line_i,   // Resolved reply line.
    output logic        serial_clock_o,   // Link clock, pad always on.
    output logic        frame_select_n_o, // Frame select, active low.
    output logic        tx_data_line_o,   // Outgoing data.
    output logic        ctl_o,            // High while a control word goes out.
    output logic        flag_o,           // Toggles once per received word.
    output logic [15:0] word_o            // Last word received.
);
    logic [15:0] cap;

    // Idle levels; as the master this end always drives its clock pad.
    initial begin
        serial_clock_o   = 1'b0;
        frame_select_n_o = 1'b1;
        tx_data_line_o   = 1'b0;
        ctl_o            = 1'b0;
        flag_o           = 1'b0;
        word_o           = 16'h0000;
    end

    task automatic half();
        repeat (HALF) @(posedge clk_sys_i);
    endtask

    // Posting costs no cycle, so framing keeps its pace between words.
    task automatic post(input logic [15:0] w);
        word_o <= w;
        flag_o <= ~flag_o;
    endtask

    // SPI variants; word k sits at ws[16*k +: 16], sent MSB first.
    task automatic spi_run(input logic cpol, input logic cpha, input int nb,
                           input logic [31:0] ws, input int nw);
        serial_clock_o <= cpol;
        half();
        frame_select_n_o <= 1'b0;
        half();
        for (int k = 0; k < nw; k++) begin
            cap = 16'h0000;
            for (int i = nb - 1; i >= 0; i--) begin
                if (!cpha) begin
                    tx_data_line_o <= ws[16*k+i];
                    half();
                end
                serial_clock_o <= ~cpol;
                if (cpha) tx_data_line_o <= ws[16*k+i];
                else cap = {cap[14:0], rx_data_line_i};
                half();
                serial_clock_o <= cpol;
                if (cpha) begin
                    cap = {cap[14:0], rx_data_line_i};
                    half();
                end
            end
            post(cap);
            if (k + 1 < nw && !cpha) begin
                half();
                frame_select_n_o <= 1'b1;
                repeat (2) half();
                frame_select_n_o <= 1'b0;
                half();
            end
        end
        half();
        frame_select_n_o <= 1'b1;
        tx_data_line_o   <= 1'b0;
    endtask

    // Command format: control byte, one wait clock (i of -1), then the reply.
    task automatic cmd_run(input int nb, input logic [15:0] cs, input int nf);
        serial_clock_o <= 1'b0;
        half();
        frame_select_n_o <= 1'b0;
        for (int k = 0; k < nf; k++) begin
            ctl_o <= 1'b1;
            for (int i = 7; i >= -1; i--) begin
                tx_data_line_o <= (i < 0) ? 1'b0 : cs[8*k+i];
                half();
                serial_clock_o <= 1'b1;
                half();
                serial_clock_o <= 1'b0;
            end
            ctl_o <= 1'b0;
            cap = 16'h0000;
            for (int i = 0; i < nb; i++) begin
                half();
                serial_clock_o <= 1'b1;
                cap = {cap[14:0], rx_data_line_i};
                half();
                serial_clock_o <= 1'b0;
            end
            post(cap);
        end
        half();
        frame_select_n_o <= 1'b1;
        tx_data_line_o   <= 1'b0;
    endtask
endmodule

// ---- tb/sync_serial_frame_sequencer_tb_top.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Bench: register traffic, link frames and result watchers.
// ****************************************************************
module sync_serial_frame_sequencer_tb_top;
    logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic        sclk, fss_n, mosi, ctl, flag, flag_q = 1'b0, rd_q = 1'b0, sclk_q = 1'b0;
    logic        rx_o, rx_oe, last_q = 1'b0, rx_wire, refuse = 1'b0;
    logic [15:0] word, lfsr_q = 16'h0027;
    logic [31:0] exp_rd[$];
    logic [15:0] exp_link[$];
    int          failures = 0, check_count = 0, hi_cnt = 0, cycles = 0;

    // A released reply line shows the inverse of its last value, never a kind guess.
    assign rx_wire = rx_oe ? rx_o : ~last_q;
    always #5 clk_sys_i = ~clk_sys_i;

    sync_serial_frame_responder DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .serial_clock_i(sclk), .frame_select_i(fss_n),
        .tx_data_line_i(mosi), .rx_data_line_o(rx_o), .rx_data_line_oe_o(rx_oe));

    serial_master_model #(.HALF(4)) partner (
        .clk_sys_i(clk_sys_i), .rx_data_line_i(rx_wire), .serial_clock_o(sclk),
        .frame_select_n_o(fss_n), .tx_data_line_o(mosi), .ctl_o(ctl),
        .flag_o(flag), .word_o(word));

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Register port; every access leaves one idle cycle so no strobe is set twice.
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        exp_rd.push_back(e);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
    endtask

    // Watchers: read data, words taken by the master, reply-line drive, timeout.
    always @(posedge clk_sys_i) begin
        rd_q   <= reg_rd_i;
        sclk_q <= sclk;
        flag_q <= flag;
        hi_cnt <= fss_n ? hi_cnt + 1 : 0;
        cycles <= cycles + 1;
        if (rx_oe) last_q <= rx_o;
        if (rd_q) check(reg_rdata_o, (exp_rd.size() > 0) ? exp_rd.pop_front() : 32'hx);
        if (flag !== flag_q && !refuse)
            check({16'h0, word}, (exp_link.size() > 0) ? {16'h0, exp_link.pop_front()}
                                                      : 32'hx);
        if (hi_cnt == 4) check(rx_oe, 32'h0);
        if (sclk && !sclk_q && (ctl || refuse)) check(rx_oe, 32'h0);
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end

    // Four SPI modes at 4, 16, 8 and 11 bits, command runs of one and two frames at 4 and 16 bits, then refusals.
    initial begin
        sync_serial_pkg::ctrl_t c;
        logic [15:0] rep, mk;
        logic [31:0] ws;
        int          nb;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        reg_read(sync_serial_pkg::OFS_CTRL, 32'h70);
        reg_read(sync_serial_pkg::OFS_STATUS, 32'h0);
        reg_write(8'h10, 32'h1ff);
        reg_read(8'h10, 32'h0);
        reg_read(sync_serial_pkg::OFS_CTRL, 32'h70);
        c = sync_serial_pkg::CTRL_RESET;
        c.enable = 1'b1;
        for (int m = 0; m < 6; m++) begin
            nb = (m % 4 == 0) ? 4 : (m % 4 == 1) ? 16 : (m == 2) ? 8 : 11;
            mk = 16'((32'h1 << nb) - 1);
            rep = rnd();
            ws[15:0] = rnd();
            ws[31:16] = rnd();
            c.data_size_select = 4'(nb - 1);
            c.cpol = m[0] && m < 4;
            c.cpha = m[1] && m < 4;
            c.fmt = (m < 4) ? sync_serial_pkg::FMT_SPI : sync_serial_pkg::FMT_CMDRESP;
            reg_write(sync_serial_pkg::OFS_REPLY, {16'h0, rep});
            reg_write(sync_serial_pkg::OFS_CTRL, 32'(c));
            repeat ((m == 4) ? 1 : 2) exp_link.push_back(rep & mk);
            if (m < 4) partner.spi_run(c.cpol, c.cpha, nb, ws, 2);
            else partner.cmd_run(nb, ws[15:0], m - 3);
            repeat (4) @(posedge clk_sys_i);
            reg_read(sync_serial_pkg::OFS_STATUS, (m == 4) ? 32'h1 : 32'h5);
            reg_read(sync_serial_pkg::OFS_RXWORD, (m < 4) ? {16'h0, ws[31:16] & mk}
                     : {24'h0, (m == 4) ? ws[7:0] : ws[15:8]});
            reg_read(sync_serial_pkg::OFS_STATUS, 32'h0);
        end
        for (int r = 0; r < 3; r++) begin
            c.enable = (r != 0);
            c.fmt = (r == 0) ? sync_serial_pkg::FMT_SPI
                  : (r == 1) ? sync_serial_pkg::FMT_PULSE : 2'h3;
            reg_write(sync_serial_pkg::OFS_CTRL, 32'(c));
            refuse <= 1'b1;
            partner.spi_run(1'b0, 1'b0, 8, 32'h5aa5, 1);
            refuse <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            reg_read(sync_serial_pkg::OFS_STATUS, 32'h0);
        end
        repeat (2) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule
